/* inc/lpsm_map.svh */
// register offsets, field positions, reset values and timing constants for the
// link power state manager; included by the package and the bench
`ifndef LPSM_MAP_SVH
`define LPSM_MAP_SVH
// register indices on the plain register port (word addresses)
`define LPSM_ADDR_W 4
`define LPSM_REG_LINK_CTL 4'h0
`define LPSM_REG_PM_CTL 4'h1
`define LPSM_REG_DEV_CAP 4'h2
`define LPSM_REG_SLOT_CAP 4'h3
`define LPSM_REG_STATUS 4'h4
`define LPSM_REG_PORT_SEL 4'h5
// link control: aspm enable bits 1:0 (bit 0 l0s, bit 1 l1)
`define LPSM_ASPM_L0S_BIT 0
`define LPSM_ASPM_L1_BIT 1
// power mgmt private control: l0s hold [15:0], l1 hold [31:16], in ref_clk cycles
`define LPSM_L0S_LSB 0
`define LPSM_L1_LSB 16
`define LPSM_HOLD_W 16
`define LPSM_PM_CTL_RST 32'h0100_0040
// device capabilities: captured scale [7:0], captured value [9:8]
`define LPSM_CSCALE_LSB 0
`define LPSM_CVALUE_LSB 8
// timing
`define LPSM_CLK_HZ 40000000
`define LPSM_ACT_HOLD_MS 200
`define LPSM_UPD_MS 40
`define LPSM_UPD_CYC ((`LPSM_CLK_HZ / 1000) * `LPSM_UPD_MS)
`define LPSM_ACT_PERIODS (`LPSM_ACT_HOLD_MS / `LPSM_UPD_MS)
`endif

/* inc/lpsm_pkg.sv */
// types for the link power state manager
// assumes lpsm_map.svh sits on the include path
`include "lpsm_map.svh"
package lpsm_pkg;
  typedef enum logic [3:0] {
    LPSM_LT_DETECT = 4'h0,
    LPSM_LT_POLLING = 4'h1,
    LPSM_LT_CONFIG = 4'h2,
    LPSM_LT_DISABLED = 4'h3,
    LPSM_LT_LOOPBACK = 4'h4,
    LPSM_LT_HOTRESET = 4'h5,
    LPSM_LT_L0 = 4'h6,
    LPSM_LT_L0S = 4'h7,
    LPSM_LT_L1 = 4'h8,
    LPSM_LT_RECOVERY = 4'h9,
    LPSM_LT_L23 = 4'hA
  } lpsm_ltssm_t;
  typedef enum logic [2:0] {
    LPSM_AS_L0 = 3'h0,
    LPSM_AS_L0S = 3'h1,
    LPSM_AS_L1_REQ = 3'h2,
    LPSM_AS_L1 = 3'h3,
    LPSM_AS_L23 = 3'h4,
    LPSM_AS_DOWN = 3'h5
  } lpsm_aspm_t;
  // per-port traffic indications from the link layers
  typedef struct packed {
    logic tlp_pending;
    logic credit_ok;
    logic dllp_pending;
    logic rx_in_l0s;
    logic tlp_act;
    logic in_d3;
  } lpsm_port_in_t;
  // set slot power limit message received on the upstream port
  typedef struct packed {
    logic valid;
    logic [7:0] byte0;
    logic [7:0] byte1;
  } lpsm_sspl_t;
endpackage

/* rtl/lpsm_core.sv */
// link power state manager for all ports of a switch; port 0 is upstream
// assumes ltssm state, traffic and message strobes arrive synchronous to ref_clk
`timescale 1ns/1ps
`default_nettype none
module lpsm_core
  import lpsm_pkg::*;
#(
  parameter int NPORT = 7,
  parameter int UPD_CYC = `LPSM_UPD_CYC
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // register port
  input wire logic [`LPSM_ADDR_W-1:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // link side, per port
  input wire lpsm_ltssm_t ltssm [NPORT],
  input wire lpsm_port_in_t port_in [NPORT],
  input wire logic [NPORT-1:0] l1_ack,
  input wire logic [NPORT-1:0] l1_nak,
  input wire logic [NPORT-1:0] turn_off_ack,
  input wire lpsm_sspl_t sspl_rx,
  // actions toward the link layers
  output logic [NPORT-1:0] sspl_send,
  output logic [NPORT-1:0] l0s_enter,
  output logic [NPORT-1:0] l1_request,
  output logic [NPORT-1:0] traffic_block,
  output logic [NPORT-1:0] link_down,
  // expander status
  output logic [NPORT-1:0] port_link_up_out,
  output logic [NPORT-1:0] port_activity_out
);
  localparam int PW = $clog2(NPORT);
  localparam int HW = `LPSM_HOLD_W;

  function automatic logic dl_up(input lpsm_ltssm_t s);
    dl_up = (s == LPSM_LT_L0) || (s == LPSM_LT_L0S) || (s == LPSM_LT_L1) ||
            (s == LPSM_LT_RECOVERY);
  endfunction

  function automatic logic is_down(input lpsm_ltssm_t s);
    is_down = (s == LPSM_LT_DETECT) || (s == LPSM_LT_POLLING) || (s == LPSM_LT_CONFIG) ||
              (s == LPSM_LT_DISABLED) || (s == LPSM_LT_LOOPBACK) || (s == LPSM_LT_HOTRESET);
  endfunction

  // registers
  logic [1:0] aspm_en_q [NPORT];
  logic [31:0] pm_ctl_q [NPORT];
  logic [7:0] cap_scale_q;
  logic [1:0] cap_value_q;
  logic [31:0] slot_cap_q [NPORT];
  logic [PW-1:0] port_sel_q;
  logic [31:0] rdata_q;
  lpsm_aspm_t st_q [NPORT];
  logic [NPORT-1:0] up_now;
  logic [NPORT-1:0] up_prev_q;
  logic [NPORT-1:0] active_ds;
  logic [NPORT-1:0] rx_l0s;
  logic [NPORT-1:0] in_l1;
  logic [NPORT-1:0] l0s_cond;
  logic [NPORT-1:0] l1_cond;
  logic [NPORT-1:0] sspl_wr;
  logic wr_slot;
  logic ds_all_l0s;
  logic ds_all_l1;

  assign wr_slot = reg_wr && (reg_addr == `LPSM_REG_SLOT_CAP);

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      port_sel_q <= '0;
    end else if (reg_wr && reg_addr == `LPSM_REG_PORT_SEL) begin
      port_sel_q <= (reg_wdata[PW-1:0] < PW'(NPORT)) ? reg_wdata[PW-1:0] : '0;
    end
  end

  // upstream captures from received message
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      cap_scale_q <= 8'h00;
      cap_value_q <= 2'h0;
    end else if (sspl_rx.valid) begin
      cap_scale_q <= sspl_rx.byte0;
      cap_value_q <= sspl_rx.byte1[1:0];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      rdata_q <= 32'h0000_0000;
    end else if (reg_rd) begin
      case (reg_addr)
        `LPSM_REG_LINK_CTL: rdata_q <= {30'h0, aspm_en_q[port_sel_q]};
        `LPSM_REG_PM_CTL: rdata_q <= pm_ctl_q[port_sel_q];
        `LPSM_REG_DEV_CAP: rdata_q <= {22'h0, cap_value_q, cap_scale_q};
        `LPSM_REG_SLOT_CAP: rdata_q <= slot_cap_q[port_sel_q];
        `LPSM_REG_STATUS: rdata_q <= {25'h0, up_now[port_sel_q], 3'h0, st_q[port_sel_q]};
        `LPSM_REG_PORT_SEL: rdata_q <= 32'(port_sel_q);
        default: rdata_q <= 32'h0000_0000;
      endcase
    end else begin
      rdata_q <= 32'h0000_0000;
    end
  end
  assign reg_rdata = rdata_q;

  always_comb begin
    ds_all_l0s = 1'b1;
    ds_all_l1 = 1'b1;
    for (int i = 1; i < NPORT; i++) begin
      if (active_ds[i] && !rx_l0s[i]) ds_all_l0s = 1'b0;
      if (active_ds[i] && !in_l1[i]) ds_all_l1 = 1'b0;
    end
  end

  // update period tick shared by all expander outputs
  logic [$clog2(UPD_CYC)-1:0] upd_cnt_q;
  logic upd_tick;
  assign upd_tick = (upd_cnt_q == ($bits(upd_cnt_q))'(UPD_CYC - 1));
  always_ff @(posedge ref_clk) begin
    if (!rst_n) upd_cnt_q <= '0;
    else if (upd_tick) upd_cnt_q <= '0;
    else upd_cnt_q <= upd_cnt_q + 1'b1;
  end

  genvar g;
  generate
    for (g = 0; g < NPORT; g++) begin : g_port
      logic [HW-1:0] l0s_cnt_q;
      logic [HW-1:0] l1_cnt_q;
      logic [$clog2(`LPSM_ACT_PERIODS+1)-1:0] act_left_q;
      logic act_seen_q;
      logic l0s_hit;
      logic l1_hit;
      logic idle;
      logic [HW-1:0] l0s_lim;
      logic [HW-1:0] l1_lim;

      assign up_now[g] = dl_up(ltssm[g]);
      assign active_ds[g] = up_now[g] && !port_in[g].in_d3;
      assign rx_l0s[g] = port_in[g].rx_in_l0s;
      assign in_l1[g] = (ltssm[g] == LPSM_LT_L1);
      assign link_down[g] = is_down(ltssm[g]);
      assign l0s_lim = pm_ctl_q[g][`LPSM_L0S_LSB +: HW];
      assign l1_lim = pm_ctl_q[g][`LPSM_L1_LSB +: HW];
      assign idle = (!port_in[g].tlp_pending || !port_in[g].credit_ok) &&
                    !port_in[g].dllp_pending;
      if (g == 0) begin : g_up
        assign l0s_cond[g] = ds_all_l0s && idle;
        assign l1_cond[g] = ds_all_l1 && idle;
      end else begin : g_dn
        assign l0s_cond[g] = rx_l0s[0] && idle;
        assign l1_cond[g] = 1'b0;
      end

      always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
          aspm_en_q[g] <= 2'h0;
          pm_ctl_q[g] <= `LPSM_PM_CTL_RST;
          slot_cap_q[g] <= 32'h0000_0000;
        end else if (reg_wr && port_sel_q == PW'(g)) begin
          if (reg_addr == `LPSM_REG_LINK_CTL) aspm_en_q[g] <= reg_wdata[1:0];
          if (reg_addr == `LPSM_REG_PM_CTL) pm_ctl_q[g] <= reg_wdata;
          if (reg_addr == `LPSM_REG_SLOT_CAP) slot_cap_q[g] <= reg_wdata;
        end
      end

      // hold counters clear on any condition drop or when aspm off
      always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
          l0s_cnt_q <= '0;
          l1_cnt_q <= '0;
        end else begin
          if (!l0s_cond[g] || !aspm_en_q[g][`LPSM_ASPM_L0S_BIT] || st_q[g] != LPSM_AS_L0)
            l0s_cnt_q <= '0;
          else if (l0s_cnt_q != l0s_lim)
            l0s_cnt_q <= l0s_cnt_q + 1'b1;
          if (!l1_cond[g] || !aspm_en_q[g][`LPSM_ASPM_L1_BIT] ||
              !(st_q[g] == LPSM_AS_L0 || st_q[g] == LPSM_AS_L0S))
            l1_cnt_q <= '0;
          else if (l1_cnt_q != l1_lim)
            l1_cnt_q <= l1_cnt_q + 1'b1;
        end
      end
      assign l0s_hit = l0s_cond[g] && aspm_en_q[g][`LPSM_ASPM_L0S_BIT] && l0s_cnt_q == l0s_lim;
      assign l1_hit = l1_cond[g] && aspm_en_q[g][`LPSM_ASPM_L1_BIT] && l1_cnt_q == l1_lim;

      // aspm state walks on its own; only the timed l0s and l1 entries and the drop from LPSM_AS_L1_REQ back to LPSM_AS_L0 wait on the enables
      always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
          st_q[g] <= LPSM_AS_DOWN;
        end else if (!up_now[g] && ltssm[g] != LPSM_LT_L23) begin
          st_q[g] <= LPSM_AS_DOWN;
        end else begin
          case (st_q[g])
            LPSM_AS_DOWN: if (up_now[g]) st_q[g] <= LPSM_AS_L0;
            LPSM_AS_L0: begin
              if (turn_off_ack[g]) st_q[g] <= LPSM_AS_L23;
              else if (ltssm[g] == LPSM_LT_L1) st_q[g] <= LPSM_AS_L1;
              else if (l1_hit) st_q[g] <= LPSM_AS_L1_REQ;
              else if (l0s_hit) st_q[g] <= LPSM_AS_L0S;
            end
            LPSM_AS_L0S: begin
              if (turn_off_ack[g]) st_q[g] <= LPSM_AS_L23;
              else if (l1_hit) st_q[g] <= LPSM_AS_L1_REQ;
              else if (!l0s_cond[g]) st_q[g] <= LPSM_AS_L0;
            end
            LPSM_AS_L1_REQ: begin
              if (!aspm_en_q[g][`LPSM_ASPM_L1_BIT]) st_q[g] <= LPSM_AS_L0;
              else if (l1_ack[g]) st_q[g] <= LPSM_AS_L1;
              else if (l1_nak[g]) st_q[g] <= LPSM_AS_L0S;
            end
            LPSM_AS_L1: if (ltssm[g] == LPSM_LT_L0) st_q[g] <= LPSM_AS_L0;
            LPSM_AS_L23: if (ltssm[g] != LPSM_LT_L23) st_q[g] <= LPSM_AS_DOWN;
            default: st_q[g] <= LPSM_AS_DOWN;
          endcase
        end
      end
      assign l0s_enter[g] = (st_q[g] == LPSM_AS_L0S);
      assign l1_request[g] = (st_q[g] == LPSM_AS_L1_REQ) && aspm_en_q[g][`LPSM_ASPM_L1_BIT];
      assign traffic_block[g] = (st_q[g] == LPSM_AS_L23);

      // slot power message on downstream ports
      always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
          up_prev_q[g] <= 1'b0;
          sspl_send[g] <= 1'b0;
        end else begin
          up_prev_q[g] <= up_now[g];
          if (g == 0)
            sspl_send[g] <= 1'b0;
          else
            sspl_send[g] <= sspl_wr[g] || (up_now[g] && !up_prev_q[g]);
        end
      end
      assign sspl_wr[g] = wr_slot && port_sel_q == PW'(g) && up_now[g];

      // activity latch, hold counted in update periods
      always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
          act_seen_q <= 1'b0;
        end else if (port_in[g].tlp_act) begin
          act_seen_q <= 1'b1;
        end else if (upd_tick) begin
          act_seen_q <= 1'b0;
        end
      end
      always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
          act_left_q <= '0;
          port_activity_out[g] <= 1'b0;
          port_link_up_out[g] <= 1'b0;
        end else if (upd_tick) begin
          port_link_up_out[g] <= up_now[g];
          if (act_seen_q || port_in[g].tlp_act) begin
            act_left_q <= ($bits(act_left_q))'(`LPSM_ACT_PERIODS);
            port_activity_out[g] <= 1'b1;
          end else if (act_left_q > 1) begin
            act_left_q <= act_left_q - 1'b1;
          end else begin
            act_left_q <= '0;
            port_activity_out[g] <= 1'b0;
          end
        end
      end
    end
  endgenerate

  // assertions
  property p_cap_scale;
    @(posedge ref_clk) disable iff (!rst_n)
      sspl_rx.valid |=> cap_scale_q == $past(sspl_rx.byte0);
  endproperty
  a_cap_scale: assert property (p_cap_scale) else $error("scale not captured");
  property p_cap_value;
    @(posedge ref_clk) disable iff (!rst_n)
      sspl_rx.valid |=> cap_value_q == $past(sspl_rx.byte1[1:0]);
  endproperty
  a_cap_value: assert property (p_cap_value) else $error("value not captured");
  property p_sspl_wr;
    @(posedge ref_clk) disable iff (!rst_n)
      (wr_slot && port_sel_q != '0 && up_now[port_sel_q]) |=> sspl_send[$past(port_sel_q)];
  endproperty
  a_sspl_wr: assert property (p_sspl_wr) else $error("no message on slot write");
  property p_sspl_up;
    @(posedge ref_clk) disable iff (!rst_n)
      (up_now[1] && !up_prev_q[1]) |=> sspl_send[1];
  endproperty
  a_sspl_up: assert property (p_sspl_up) else $error("no message on link up");
  property p_no_ds_l1;
    @(posedge ref_clk) disable iff (!rst_n) l1_request[NPORT-1:1] == '0;
  endproperty
  a_no_ds_l1: assert property (p_no_ds_l1) else $error("downstream l1 request");
  property p_l1_gate;
    @(posedge ref_clk) disable iff (!rst_n)
      $rose(l1_request[0]) |-> $past(ds_all_l1) && $past(aspm_en_q[0][`LPSM_ASPM_L1_BIT]);
  endproperty
  a_l1_gate: assert property (p_l1_gate) else $error("l1 request with busy ports");
  property p_l1_nak;
    @(posedge ref_clk) disable iff (!rst_n)
      (st_q[0] == LPSM_AS_L1_REQ && up_now[0] && aspm_en_q[0][1] && !l1_ack[0] && l1_nak[0])
      |=> st_q[0] == LPSM_AS_L0S;
  endproperty
  a_l1_nak: assert property (p_l1_nak) else $error("reject did not give l0s");
  property p_l0s_hold;
    @(posedge ref_clk) disable iff (!rst_n)
      (st_q[1] == LPSM_AS_L0 && !l0s_cond[1]) |=> g_port[1].l0s_cnt_q == '0;
  endproperty
  a_l0s_hold: assert property (p_l0s_hold) else $error("hold count not restarted");
  property p_aspm_off;
    @(posedge ref_clk) disable iff (!rst_n)
      (st_q[1] == LPSM_AS_L0 && up_now[1] && !aspm_en_q[1][0] && !turn_off_ack[1] &&
       ltssm[1] == LPSM_LT_L0) |=> st_q[1] == LPSM_AS_L0;
  endproperty
  a_aspm_off: assert property (p_aspm_off) else $error("transition with aspm off");
  property p_upd_rate;
    @(posedge ref_clk) disable iff (!rst_n)
      ($changed(port_activity_out) || $changed(port_link_up_out)) |-> $past(upd_tick);
  endproperty
  a_upd_rate: assert property (p_upd_rate) else $error("status changed off tick");
  property p_link_up;
    @(posedge ref_clk) disable iff (!rst_n)
      upd_tick |=> port_link_up_out == $past(up_now);
  endproperty
  a_link_up: assert property (p_link_up) else $error("link-up status not refreshed");
  property p_turn_off;
    @(posedge ref_clk) disable iff (!rst_n)
      (st_q[2] == LPSM_AS_L0 && turn_off_ack[2] && ltssm[2] == LPSM_LT_L23)
      |=> traffic_block[2];
  endproperty
  a_turn_off: assert property (p_turn_off) else $error("traffic not blocked");
  property p_l1_ack;
    @(posedge ref_clk) disable iff (!rst_n)
      (st_q[0] == LPSM_AS_L1_REQ && up_now[0] && aspm_en_q[0][`LPSM_ASPM_L1_BIT] && l1_ack[0])
      |=> st_q[0] == LPSM_AS_L1;
  endproperty
  a_l1_ack: assert property (p_l1_ack) else $error("acknowledge did not give l1");
  c_l23: cover property (@(posedge ref_clk) disable iff (!rst_n) $rose(traffic_block[2]));
  c_l1_req: cover property (@(posedge ref_clk) disable iff (!rst_n) $rose(l1_request[0]));
  c_l0s: cover property (@(posedge ref_clk) disable iff (!rst_n) $rose(l0s_enter[1]));
  c_act: cover property (@(posedge ref_clk) disable iff (!rst_n) $rose(port_activity_out[1]));
endmodule
`default_nettype wire

/* bench/lpsm_link_partner.sv */
// behavioural link partner facing the upstream port, answering l1 entry requests
// assumes the request is a level sampled on ref_clk rising edges
`timescale 1ns/1ps
`default_nettype none
module lpsm_link_partner (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // request and answer policy
  input wire logic l1_req,
  input wire logic answer_nak,
  input wire logic [3:0] answer_wait,
  // one-cycle answers
  output logic l1_ack,
  output logic l1_nak
);
  logic [3:0] wait_q;
  logic done_q;
  // one answer per request, only while the request stands
  always_ff @(posedge ref_clk) begin
    l1_ack <= 1'b0;
    l1_nak <= 1'b0;
    if (!rst_n || !l1_req) begin
      wait_q <= 4'h0;
      done_q <= 1'b0;
    end else if (!done_q) begin
      if (wait_q == answer_wait) begin
        l1_ack <= !answer_nak;
        l1_nak <= answer_nak;
        done_q <= 1'b1;
      end else begin
        wait_q <= wait_q + 4'h1;
      end
    end
  end
endmodule
`default_nettype wire

/* bench/test_lpsm.sv */
// self-checking bench for the link power state manager, port 0 upstream
// assumes lpsm_pkg, lpsm_map.svh and the link partner model are compiled first
`timescale 1ns/1ps
`default_nettype none
`include "lpsm_map.svh"
module test_lpsm
  import lpsm_pkg::*;
;
  localparam int NP = 7;
  // short update period keeps the 200 ms hold at five periods without a long run
  localparam int UPD = 20;
  logic ref_clk, rst_n, reg_wr, reg_rd;
  logic [`LPSM_ADDR_W-1:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, d;
  lpsm_ltssm_t ltssm [NP];
  lpsm_port_in_t port_in [NP];
  logic [NP-1:0] l1_ack, l1_nak, turn_off_ack;
  logic [NP-1:0] sspl_send, l0s_enter, l1_request, traffic_block, link_down;
  logic [NP-1:0] port_link_up_out, port_activity_out;
  lpsm_sspl_t sspl_rx;
  logic pa, pn, ans_nak;
  logic [3:0] ans_wait;
  int bad_count, total_checks, cycles, c, h;
  assign l1_ack = {{(NP-1){1'b0}}, pa};
  assign l1_nak = {{(NP-1){1'b0}}, pn};
  lpsm_core #(.NPORT(NP), .UPD_CYC(UPD)) dut (.ref_clk(ref_clk), .rst_n(rst_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .ltssm(ltssm), .port_in(port_in), .l1_ack(l1_ack),
    .l1_nak(l1_nak), .turn_off_ack(turn_off_ack), .sspl_rx(sspl_rx),
    .sspl_send(sspl_send), .l0s_enter(l0s_enter), .l1_request(l1_request),
    .traffic_block(traffic_block), .link_down(link_down),
    .port_link_up_out(port_link_up_out), .port_activity_out(port_activity_out));
  lpsm_link_partner partner (.ref_clk(ref_clk), .rst_n(rst_n), .l1_req(l1_request[0]),
    .answer_nak(ans_nak), .answer_wait(ans_wait), .l1_ack(pa), .l1_nak(pn));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] v);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask
  // counts slot power message pulses of one port over n cycles
  task automatic pulses(input int p, input int n);
    c = 0;
    repeat (n) begin
      #1;
      c += (sspl_send[p] === 1'b1);
      @(posedge ref_clk);
    end
  endtask
  task automatic t_reset();
    tick(1);
    chk(port_link_up_out, '0);
    chk(link_down, {NP{1'b1}});
    rd(`LPSM_REG_PM_CTL);
    chk(d, 32'h0100_0040);
    rd(4'hF);
    chk(d, 32'h0);
  endtask
  task automatic t_capture();
    @(posedge ref_clk);
    sspl_rx <= '{valid: 1'b1, byte0: 8'hA5, byte1: 8'hFE};
    @(posedge ref_clk);
    sspl_rx.valid <= 1'b0;
    rd(`LPSM_REG_DEV_CAP);
    chk(d[7:0], 8'hA5);
    chk(d[9:8], 2'h2);
  endtask
  task automatic t_slot();
    @(posedge ref_clk);
    ltssm[0] <= LPSM_LT_L0;
    pulses(0, 6);
    chk(c, 0);
    @(posedge ref_clk);
    ltssm[1] <= LPSM_LT_L0;
    pulses(1, 6);
    chk(c, 1);
    wr(`LPSM_REG_PORT_SEL, 32'h1);
    wr(`LPSM_REG_SLOT_CAP, 32'h0000_1234);
    pulses(1, 4);
    chk(c, 1);
    wr(`LPSM_REG_PORT_SEL, 32'h4);
    wr(`LPSM_REG_SLOT_CAP, 32'h0000_5678);
    pulses(4, 4);
    chk(c, 0);
  endtask
  task automatic t_states();
    for (int s = 0; s < 10; s++) begin
      @(posedge ref_clk);
      ltssm[2] <= lpsm_ltssm_t'(4'(s));
      tick(2 * UPD + 2);
      chk(link_down[2], s < 6);
      chk(port_link_up_out[2], s >= 6);
    end
  endtask
  task automatic t_l0s();
    wr(`LPSM_REG_PORT_SEL, 32'h1);
    wr(`LPSM_REG_LINK_CTL, 32'h0);
    wr(`LPSM_REG_PM_CTL, 32'h0100_0007);
    @(posedge ref_clk);
    port_in[0].rx_in_l0s <= 1'b1;
    port_in[1].tlp_pending <= 1'b0;
    tick(30);
    chk(l0s_enter[1], 1'b0);
    @(posedge ref_clk);
    port_in[1].tlp_pending <= 1'b1;
    wr(`LPSM_REG_LINK_CTL, 32'h1);
    @(posedge ref_clk);
    port_in[1].tlp_pending <= 1'b0;
    repeat (5) @(posedge ref_clk);
    port_in[1].tlp_pending <= 1'b1;
    @(posedge ref_clk);
    port_in[1].tlp_pending <= 1'b0;
    tick(6);
    chk(l0s_enter[1], 1'b0);
    c = 0;
    while (l0s_enter[1] !== 1'b1 && c < 10) begin
      tick(1);
      c++;
    end
    chk(l0s_enter[1], 1'b1);
    @(posedge ref_clk);
    port_in[1].tlp_pending <= 1'b1;
  endtask
  task automatic t_activity();
    @(posedge ref_clk);
    ltssm[3] <= LPSM_LT_L0;
    tick(2 * UPD);
    @(posedge ref_clk);
    port_in[3].tlp_act <= 1'b1;
    @(posedge ref_clk);
    port_in[3].tlp_act <= 1'b0;
    c = 0;
    while (port_activity_out[3] !== 1'b1 && c < 3 * UPD) begin
      tick(1);
      c++;
    end
    chk(port_activity_out[3], 1'b1);
    h = 0;
    // a second packet part way through must stretch the hold
    while (port_activity_out[3] === 1'b1 && h < 12 * UPD) begin
      @(posedge ref_clk);
      port_in[3].tlp_act <= (h == 40);
      #1;
      h++;
    end
    chk(h >= 40 + 4 * UPD, 1'b1);
    chk(h <= 40 + 7 * UPD, 1'b1);
  endtask
  task automatic t_turnoff();
    @(posedge ref_clk);
    ltssm[2] <= LPSM_LT_L0;
    tick(3);
    @(posedge ref_clk);
    turn_off_ack[2] <= 1'b1;
    ltssm[2] <= LPSM_LT_L23;
    @(posedge ref_clk);
    turn_off_ack[2] <= 1'b0;
    tick(4);
    chk(traffic_block[2], 1'b1);
    chk(traffic_block[1], 1'b0);
  endtask
  task automatic t_l1();
    @(posedge ref_clk);
    for (int i = 1; i < NP; i++) begin
      ltssm[i] <= (i == 1) ? LPSM_LT_L0 : LPSM_LT_L1;
      port_in[i].rx_in_l0s <= 1'b1;
    end
    port_in[0].tlp_pending <= 1'b0;
    wr(`LPSM_REG_PORT_SEL, 32'h0);
    wr(`LPSM_REG_PM_CTL, 32'h000F_0003);
    wr(`LPSM_REG_LINK_CTL, 32'h3);
    tick(40);
    chk(l1_request[0], 1'b0);
    wr(`LPSM_REG_LINK_CTL, 32'h1);
    @(posedge ref_clk);
    ans_nak <= 1'b1;
    ans_wait <= 4'h0;
    port_in[1].in_d3 <= 1'b1;
    tick(40);
    chk(l1_request[0], 1'b0);
    wr(`LPSM_REG_LINK_CTL, 32'h3);
    c = 0;
    while (pn !== 1'b1 && c < 40) begin
      tick(1);
      c++;
    end
    chk(pn, 1'b1);
    tick(2);
    chk(l0s_enter[0], 1'b1);
    rd(`LPSM_REG_STATUS);
    chk(d[2:0], LPSM_AS_L0S);
    @(posedge ref_clk);
    ans_nak <= 1'b0;
    ans_wait <= 4'h5;
    c = 0;
    while (pa !== 1'b1 && c < 60) begin
      tick(1);
      c++;
    end
    chk(pa, 1'b1);
    // the partner's link settles into l1 once it has acknowledged
    @(posedge ref_clk);
    ltssm[0] <= LPSM_LT_L1;
    tick(2);
    chk(l1_request[0], 1'b0);
    rd(`LPSM_REG_STATUS);
    chk(d[2:0], LPSM_AS_L1);
  endtask
  // downstream ports watched every cycle, away from the sampling edge
  always @(negedge ref_clk) begin
    if (rst_n === 1'b1) begin
      chk(l1_request[NP-1:1], '0);
    end
  end
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 20000) begin
      bad_count++;
      conclude();
    end
  end
  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end
  initial begin
    rst_n = 1'b0;
    {reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
    {turn_off_ack, sspl_rx, ans_nak, ans_wait} = '0;
    for (int i = 0; i < NP; i++) begin
      ltssm[i] = LPSM_LT_DETECT;
      port_in[i] = '{tlp_pending: 1'b1, credit_ok: 1'b1, default: 1'b0};
    end
    repeat (8) @(posedge ref_clk);
    rst_n <= 1'b1;
    t_reset();
    t_capture();
    t_slot();
    t_states();
    t_l0s();
    t_activity();
    t_turnoff();
    t_l1();
    conclude();
  end
endmodule
`default_nettype wire
